// ### core/pfs_pkg.sv
// Package for the partitioned state machine with illegal-state trap.
// Assumes a single 40 MHz clock and a synchronous active-high reset.
package pfs_pkg;

  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int        SV_W      = 2;        // State variables per half
  localparam logic [1:0] SV_RST   = 2'h0;     // All-zero value after reset
  localparam logic [1:0] L_START  = 2'h0;     // Left half starting state
  localparam logic [1:0] L_RUN    = 2'h1;     // Left half working state
  localparam logic [1:0] L_IDLE   = 2'h3;     // Left half idle state
  localparam logic [1:0] R_IDLE   = 2'h0;     // Right half idle state
  localparam logic [1:0] R_WORK   = 2'h1;     // Right half first state
  localparam logic [1:0] R_DONE   = 2'h3;     // Right half second state
  localparam int        SYNC_LEN  = 2;        // Flip-flops in each input synchroniser

endpackage

// ### core/pfs_link_if.sv
// Interface carrying each half's state to the other half.
// Assumes both halves run on the same clock.
`timescale 1ns/10ps
interface pfs_link_if;
  logic [1:0] left_sv;   // Left half state variables
  logic [1:0] right_sv;  // Right half state variables
  logic       trap;      // Registered illegal-state flag

  modport left_side
  (
    output left_sv,
    input  right_sv,
    input  trap
  );
  modport right_side
  (
    output right_sv,
    input  left_sv,
    input  trap
  );
endinterface

// ### core/pfs_right.sv
// Right half of the partitioned machine.
// Assumes synchronised inputs and the shared trap flag from the top.
`timescale 1ns/10ps
module pfs_right
  import pfs_pkg::*;
(
  input  wire logic       sys_clk,   // Machine clock
  input  wire logic       rst,       // Synchronous reset
  input  wire logic       go_s,      // Synchronised start condition
  input  wire logic       fin_s,     // Synchronised finish condition
  pfs_link_if.right_side  link       // State exchange with left half
);
  logic [1:0] sv_ff;
  logic [1:0] nxt_sv;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Idle leaves only when left is in the source state of the crossing
  always_comb
  begin
    nxt_sv = sv_ff;
    case (sv_ff)
      R_IDLE:
      begin
        if (go_s && (link.left_sv == L_RUN))
          nxt_sv = R_WORK;
      end
      R_WORK:
      begin
        if (fin_s)
          nxt_sv = R_DONE;
      end
      R_DONE:
      begin
        // Return to idle flips both bits; fin is synchronised, so no race
        if (!fin_s)
          nxt_sv = R_IDLE;
      end
      default: nxt_sv = R_IDLE;
    endcase
  end

  // State register, async-style clear from registered trap flag
  always_ff @(posedge sys_clk or posedge link.trap)
  begin
    if (link.trap)
      sv_ff <= SV_RST;
    else if (rst)
      sv_ff <= R_IDLE;
    else
      sv_ff <= nxt_sv;
  end

  assign link.right_sv = sv_ff;
endmodule

// ### core/pfs_top.sv
// Top of the partitioned state machine with illegal-state trap.
// Assumes go, fin and abort are asynchronous pins; one clock sys_clk.
// Summary of operation
// - Bad-state flag is the inverse of OR of all legal state decodes.
// - Bad flag is registered; its register clears every state variable asynchronously.
// - Landing in an undefined state sets flag and zeroes all state bits.
// - Starting state encodes every state variable as zero.
// - All inputs are synchronised to the clock before next-state logic.
// - Input-dependent transitions change exactly one state bit, except the returns to zero from L_IDLE and R_DONE, which flip both.
// - No transition depends on more than one unsynchronised input.
// - Each state decodes as a single product of state variables.
// - Two halves each with idle state; only one half active.
// - Crossing: active half goes idle, idle half enters target, same edge.
// - Transition into idle uses the crossing transition's own condition.
// - Leaving idle needs original condition and other half in source state.
// - Idle holds when none of its leaving conditions is true.
// - Same-source same-destination transitions merge with ORed conditions.
`timescale 1ns/10ps
module pfs_top
  import pfs_pkg::*;
(
  input  wire logic       sys_clk,     // 40 MHz machine clock
  input  wire logic       rst,         // Synchronous reset, active high
  input  wire logic       go,          // Asynchronous start request
  input  wire logic       fin,         // Asynchronous finish request
  input  wire logic       abort,       // Asynchronous abort request
  output logic [1:0]      left_state,  // Left half state variables
  output logic [1:0]      right_state, // Right half state variables
  output logic            trap_seen    // Registered illegal-state flag
);
  import pfs_pkg::*;

  pfs_link_if link ();

  logic [SYNC_LEN-1:0] go_sync_ff;
  logic [SYNC_LEN-1:0] fin_sync_ff;
  logic [SYNC_LEN-1:0] abort_sync_ff;
  logic                go_s;
  logic                fin_s;
  logic                abort_s;
  logic [1:0]          left_ff;
  logic [1:0]          nxt_left;
  logic                bad_state;
  logic                trap_ff;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Two flip-flops per input before any logic reads it
  always_ff @(posedge sys_clk)
  begin
    go_sync_ff    <= {go_sync_ff[0], go};
    fin_sync_ff   <= {fin_sync_ff[0], fin};
    abort_sync_ff <= {abort_sync_ff[0], abort};
  end

  assign go_s    = go_sync_ff[SYNC_LEN-1];
  assign fin_s   = fin_sync_ff[SYNC_LEN-1];
  assign abort_s = abort_sync_ff[SYNC_LEN-1];

  // ----------------------------------------
  // Left half
  // ----------------------------------------
  // Each branch reads one input only, except L_RUN which also reads abort_s; all but the return from L_IDLE flip one bit
  always_comb
  begin
    nxt_left = left_ff;
    case (left_ff)
      L_START:
      begin
        if (go_s)
          nxt_left = L_RUN;
      end
      L_RUN:
      begin
        if (go_s || abort_s)
          nxt_left = L_RUN;
        // Crossing uses go alone; the right half is idle whenever left runs
        if (!go_s)
          nxt_left = L_START;
        else
          nxt_left = L_IDLE;
      end
      L_IDLE:
      begin
        // Return when right half leaves its last state
        if (!fin_s && (link.right_sv == R_DONE))
          nxt_left = L_START;
        else
          nxt_left = L_IDLE;
      end
      default: nxt_left = L_START;
    endcase
  end

  // Left state register with trap clear
  always_ff @(posedge sys_clk or posedge trap_ff)
  begin
    if (trap_ff)
      left_ff <= SV_RST;
    else if (rst)
      left_ff <= L_START;
    else
      left_ff <= nxt_left;
  end

  // ----------------------------------------
  // Illegal-state trap
  // ----------------------------------------
  // Legal pairs: left active with right idle, or left idle with right active
  always_comb
  begin
    bad_state = !(((left_ff == L_START) && (link.right_sv == R_IDLE))
               || ((left_ff == L_RUN) && (link.right_sv == R_IDLE))
               || ((left_ff == L_IDLE) && (link.right_sv == R_WORK))
               || ((left_ff == L_IDLE) && (link.right_sv == R_DONE)));
  end

  // Flag register; its output clears both halves
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      trap_ff <= 1'b0;
    else
      trap_ff <= bad_state;
  end

  assign link.left_sv = left_ff;
  assign link.trap    = trap_ff;

  pfs_right u_right
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .go_s    (go_s),
    .fin_s   (fin_s),
    .link    (link.right_side)
  );

  assign left_state  = left_ff;
  assign right_state = link.right_sv;
  assign trap_seen   = trap_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Sampled checks other than the trap and reset ones are held off in reset and while the trap clears
  sequence s_cross;
    (left_ff == L_RUN) && go_s && (link.right_sv == R_IDLE);
  endsequence

  property p_cross;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    s_cross |=> (left_ff == L_IDLE) && (link.right_sv == R_WORK);
  endproperty
  a_cross: assert property (p_cross) else $error("crossing not simultaneous");

  property p_trap_set;
    @(posedge sys_clk) disable iff (rst)
    bad_state |=> trap_ff;
  endproperty
  a_trap_set: assert property (p_trap_set) else $error("bad state not flagged");

  property p_trap_zero;
    @(posedge sys_clk) disable iff (rst)
    trap_ff |-> (left_ff == SV_RST) && (link.right_sv == SV_RST);
  endproperty
  a_trap_zero: assert property (p_trap_zero) else $error("trap did not clear");

  property p_reset;
    @(posedge sys_clk)
    rst && !trap_ff |=> ((left_ff == L_START) && (link.right_sv == R_IDLE)) || trap_ff;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_one_active;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    ((left_ff == L_IDLE) != (link.right_sv == R_IDLE)) |=> ((left_ff == L_IDLE) != (link.right_sv == R_IDLE));
  endproperty
  a_one_active: assert property (p_one_active) else $error("both halves active");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    (left_ff == L_IDLE) && !(!fin_s && (link.right_sv == R_DONE)) |=> (left_ff == L_IDLE);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle did not hold");

  property p_leave_idle;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    ($past(left_ff) == L_IDLE) && (left_ff != L_IDLE)
      |-> ($past(link.right_sv) == R_DONE) && !$past(fin_s);
  endproperty
  a_leave_idle: assert property (p_leave_idle) else $error("idle left without source");

  // Return from done is a crossing on a synchronised input and may flip both bits
  property p_one_bit;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    !$past(trap_ff) && $changed(link.right_sv) && ($past(link.right_sv) != R_DONE)
      |-> $countones(link.right_sv ^ $past(link.right_sv)) == 1;
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("multi-bit state change");

  // Same for the left half; the return from idle may flip both bits
  property p_left_one_bit;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    !$past(trap_ff) && $changed(left_ff) && ($past(left_ff) != L_IDLE)
      |-> $countones(left_ff ^ $past(left_ff)) == 1;
  endproperty
  a_left_one_bit: assert property (p_left_one_bit) else $error("multi-bit left state change");

  // Running left half goes idle on the crossing condition alone
  property p_into_idle;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    (left_ff == L_RUN) && go_s |=> (left_ff == L_IDLE);
  endproperty
  a_into_idle: assert property (p_into_idle) else $error("left did not go idle");

  // Right half leaves idle only while left runs and the crossing fires
  property p_right_leave;
    @(posedge sys_clk) disable iff (rst || trap_ff)
    ($past(link.right_sv) == R_IDLE) && (link.right_sv != R_IDLE)
      |-> ($past(left_ff) == L_RUN) && $past(go_s);
  endproperty
  a_right_leave: assert property (p_right_leave) else $error("right left idle without source");
endmodule

// ### sim/test_pfs_top.sv
// Self-checking bench for the partitioned state machine top.
// Assumes pfs_pkg and the design files are compiled first; one 40 MHz clock.
`timescale 1ns/10ps
module test_pfs_top;
  import pfs_pkg::*;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic       sys_clk;
  logic       rst;
  logic       go;
  logic       fin;
  logic       abort;
  logic [1:0] left_state;
  logic [1:0] right_state;
  logic       trap_seen;
  int         failures;
  int         compares;

  pfs_top DUT (.sys_clk(sys_clk), .rst(rst), .go(go), .fin(fin), .abort(abort),
               .left_state(left_state), .right_state(right_state), .trap_seen(trap_seen));

  // Clock, 25 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One clock later: pair must be a legal one and no trap raised
  task automatic tick;
    logic ok;
    @(negedge sys_clk);
    ok = ({left_state, right_state} inside {4'h0, 4'h4, 4'hd, 4'hf}) ? 1'b1 : 1'b0;
    check({2'h0, trap_seen, ok}, 4'h1);
  endtask

  // Bounded wait for a state pair
  task automatic reach(input logic [1:0] l, input logic [1:0] r);
    int n;
    n = 0;
    while (n < 6 && {left_state, right_state} !== {l, r})
    begin
      tick();
      n++;
    end
    if ((n == 6) && ({left_state, right_state} !== {l, r}))
    begin
      failures++;
      close_out();
    end
  endtask

  // Pair must stand unchanged for n cycles
  task automatic hold(input logic [1:0] l, input logic [1:0] r, input int n);
    repeat (n)
    begin
      tick();
      check({left_state, right_state}, {l, r});
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    repeat (3) @(negedge sys_clk);
    check({left_state, right_state}, {L_START, R_IDLE});
    check({3'h0, trap_seen}, 4'h0);
    rst = 1'b0;
    hold(L_START, R_IDLE, 3);
    $display("test reset done");
  endtask

  // Cross to the right half and back again
  task automatic t_cross;
    go = 1'b1;
    reach(L_RUN, R_IDLE);
    reach(L_IDLE, R_WORK);
    go = 1'b0;
    hold(L_IDLE, R_WORK, 4);
    fin = 1'b1;
    reach(L_IDLE, R_DONE);
    hold(L_IDLE, R_DONE, 3);
    fin = 1'b0;
    reach(L_START, R_IDLE);
    hold(L_START, R_IDLE, 4);
    $display("test cross done");
  endtask

  // One-cycle go pulse, shorter than the usual minimum but clean here:
  // left runs, sees go gone one edge later and returns; right idle holds
  task automatic t_back;
    go = 1'b1;
    tick();
    go = 1'b0;
    reach(L_RUN, R_IDLE);
    reach(L_START, R_IDLE);
    hold(L_START, R_IDLE, 4);
    $display("test back done");
  endtask

  // Abort and stray finish cause no change, in either half
  task automatic t_abort;
    abort = 1'b1;
    fin = 1'b1;
    hold(L_START, R_IDLE, 5);
    fin = 1'b0;
    go = 1'b1;
    reach(L_IDLE, R_WORK);
    go = 1'b0;
    hold(L_IDLE, R_WORK, 5);
    abort = 1'b0;
    $display("test abort done");
  endtask

  // Reset in mid-run from the right half
  task automatic t_mid_reset;
    rst = 1'b1;
    @(negedge sys_clk);
    @(negedge sys_clk);
    check({left_state, right_state}, {L_START, R_IDLE});
    check({3'h0, trap_seen}, 4'h0);
    rst = 1'b0;
    hold(L_START, R_IDLE, 3);
    $display("test mid reset done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    go = 1'b0;
    fin = 1'b0;
    abort = 1'b0;
    t_reset();
    t_cross();
    t_back();
    t_abort();
    t_mid_reset();
    close_out();
  end
endmodule
